//--- src/adcseq_host.sv
`default_nettype none
// Notes on behaviour
// - start is written low, then high, then low to launch a conversion
// - host sets converter power enable before any start
// - clock divider is programmed first in the setup
// - host programs input source: external channel or internal signal
// - external source: channel selected with power enable, then pin set analog
// - before internal source, channel set to nonexistent code 0110..1111
// - host programs the two-bit reference select field
// - interrupt use needs global and converter enables set before start
// - host may poll busy instead, skipping interrupt enables
// - host clears interrupt request before enabling converter interrupt
module adcseq_host (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // user side
   input  wire logic        cmd_start_i,
   input  wire logic        cmd_power_down_i,
   input  wire logic [2:0]  cfg_divider_i,
   input  wire logic [2:0]  cfg_source_i,
   input  wire logic [3:0]  cfg_channel_i,
   input  wire logic [7:0]  cfg_pin_mask_i,
   input  wire logic [1:0]  cfg_reference_i,
   input  wire logic        cfg_format_i,
   input  wire logic        cfg_use_irq_i,
   output logic             busy_o,
   output logic             done_o,
   output logic [11:0]      result_o,
   // device register port
   output logic [3:0]       dev_addr_o,
   output logic [7:0]       dev_wdata_o,
   output logic             dev_wr_o,
   output logic             dev_rd_o,
   input  wire logic [7:0]  dev_rdata_i,
   input  wire logic        dev_irq_i
);
   adcseq_pkg::adcseq_state_t state_reg, state_next;
   logic [3:0]  addr_reg, addr_next;
   logic [7:0]  wdata_reg, wdata_next;
   logic        wr_reg, wr_next;
   logic        rd_reg, rd_next;
   logic [1:0]  wait_reg, wait_next;
   logic [7:0]  low_reg, low_next;
   logic [11:0] result_reg, result_next;
   logic        done_reg, done_next;
   logic        busy_reg, busy_next;
   // configuration captured at the command
   logic [2:0]  div_reg, div_next;
   logic [2:0]  src_reg, src_next;
   logic [3:0]  chan_reg, chan_next;
   logic [7:0]  pin_reg, pin_next;
   logic [1:0]  ref_reg, ref_next;
   logic        fmt_reg, fmt_next;
   logic        irq_reg, irq_next;

   logic [7:0]  rdata_sync;
   logic        irq_sync;
   logic        external;
   logic        sample;

   adcseq_sync #(.WIDTH(9)) u_sync_dev (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .d_i      ({dev_irq_i, dev_rdata_i}),
      .q_o      ({irq_sync, rdata_sync})
   );

   // first control byte: start, power enable, format, channel
   function automatic logic [7:0] ctl_first(
      input logic start, input logic en, input logic fmt, input logic [3:0] ch);
      logic [7:0] v;
      v = adcseq_pkg::BYTE_ZERO;
      v[adcseq_pkg::START_BIT]  = start;
      v[adcseq_pkg::ENABLE_BIT] = en;
      v[adcseq_pkg::FORMAT_BIT] = fmt;
      v[adcseq_pkg::CHAN_LSB +: 4] = ch;
      return v;
   endfunction

   function automatic logic [7:0] ctl_second(
      input logic [2:0] src, input logic [1:0] rs, input logic [2:0] dv);
      logic [7:0] v;
      v = adcseq_pkg::BYTE_ZERO;
      v[adcseq_pkg::SRC_LSB +: 3] = src;
      v[adcseq_pkg::REF_LSB +: 2] = rs;
      v[adcseq_pkg::DIV_LSB +: 3] = dv;
      return v;
   endfunction

   function automatic logic [7:0] int_ctl(input logic en);
      logic [7:0] v;
      v = adcseq_pkg::BYTE_ZERO;
      v[adcseq_pkg::GIE_BIT]  = en;
      v[adcseq_pkg::AIE_BIT]  = en;
      v[adcseq_pkg::AREQ_BIT] = 1'b0;
      return v;
   endfunction

   assign external = (src_reg == adcseq_pkg::SRC_EXT) ||
                     (src_reg[2:1] == adcseq_pkg::SRC_EXT_HI);
   assign sample   = rd_reg && (wait_reg == adcseq_pkg::READ_WAIT);

   always_comb begin
      state_next  = state_reg;
      addr_next   = addr_reg;
      wdata_next  = wdata_reg;
      wr_next     = 1'b0;
      rd_next     = 1'b0;
      wait_next   = '0;
      low_next    = low_reg;
      result_next = result_reg;
      done_next   = 1'b0;
      busy_next   = busy_reg;
      {div_next, src_next, chan_next} = {div_reg, src_reg, chan_reg};
      {pin_next, ref_next} = {pin_reg, ref_reg};
      {fmt_next, irq_next} = {fmt_reg, irq_reg};
      if (rd_reg && !sample) begin
         rd_next   = 1'b1;
         wait_next = wait_reg + 2'h1;
      end
      unique case (state_reg)
         adcseq_pkg::ST_IDLE: begin
            if (cmd_start_i) begin
               {div_next, src_next, chan_next} =
                  {cfg_divider_i, cfg_source_i, cfg_channel_i};
               {pin_next, ref_next} = {cfg_pin_mask_i, cfg_reference_i};
               {fmt_next, irq_next} = {cfg_format_i, cfg_use_irq_i};
               busy_next  = 1'b1;
               state_next = adcseq_pkg::ST_DIV;
            end else if (cmd_power_down_i) begin
               busy_next  = 1'b1;
               state_next = adcseq_pkg::ST_OFF;
            end
         end
         adcseq_pkg::ST_OFF: begin
            addr_next  = adcseq_pkg::ADDR_CTL_FIRST;
            wdata_next = ctl_first(1'b0, 1'b0, fmt_reg,
                                   adcseq_pkg::CHAN_NONE);
            wr_next    = 1'b1;
            busy_next  = 1'b0;
            state_next = adcseq_pkg::ST_IDLE;
         end
         adcseq_pkg::ST_DIV: begin
            // source left external until the channel is parked
            addr_next  = adcseq_pkg::ADDR_CTL_SECOND;
            wdata_next = ctl_second(adcseq_pkg::SRC_EXT, ref_reg,
                                    div_reg);
            wr_next    = 1'b1;
            state_next = adcseq_pkg::ST_PWR;
         end
         adcseq_pkg::ST_PWR: begin
            addr_next  = adcseq_pkg::ADDR_CTL_FIRST;
            wdata_next = ctl_first(1'b0, 1'b1, fmt_reg,
                            external ? chan_reg
                                     : adcseq_pkg::CHAN_NONE);
            wr_next    = 1'b1;
            state_next = external ? adcseq_pkg::ST_PIN
                                  : adcseq_pkg::ST_SRC;
         end
         adcseq_pkg::ST_PIN: begin
            addr_next  = adcseq_pkg::ADDR_PIN_SEL_B;
            wdata_next = pin_reg;
            wr_next    = 1'b1;
            state_next = adcseq_pkg::ST_SRC;
         end
         adcseq_pkg::ST_SRC: begin
            addr_next  = adcseq_pkg::ADDR_CTL_SECOND;
            wdata_next = ctl_second(src_reg, ref_reg, div_reg);
            wr_next    = 1'b1;
            state_next = adcseq_pkg::ST_IRQ_CLR;
         end
         adcseq_pkg::ST_IRQ_CLR: begin
            addr_next  = adcseq_pkg::ADDR_INT_CTL;
            wdata_next = int_ctl(1'b0);
            wr_next    = 1'b1;
            state_next = irq_reg ? adcseq_pkg::ST_IRQ_EN
                                 : adcseq_pkg::ST_START_LO;
         end
         adcseq_pkg::ST_IRQ_EN: begin
            addr_next  = adcseq_pkg::ADDR_INT_CTL;
            wdata_next = int_ctl(1'b1);
            wr_next    = 1'b1;
            state_next = adcseq_pkg::ST_START_LO;
         end
         adcseq_pkg::ST_START_LO, adcseq_pkg::ST_START_HI,
         adcseq_pkg::ST_START_END: begin
            addr_next  = adcseq_pkg::ADDR_CTL_FIRST;
            wdata_next = ctl_first(state_reg == adcseq_pkg::ST_START_HI,
                            1'b1, fmt_reg,
                            external ? chan_reg
                                     : adcseq_pkg::CHAN_NONE);
            wr_next    = 1'b1;
            state_next = (state_reg == adcseq_pkg::ST_START_LO)
                         ? adcseq_pkg::ST_START_HI
                         : (state_reg == adcseq_pkg::ST_START_HI)
                           ? adcseq_pkg::ST_START_END
                           : adcseq_pkg::ST_WAIT;
         end
         adcseq_pkg::ST_WAIT: begin
            // one idle cycle between polls lets the strobe drop
            if (!irq_reg) begin
               addr_next  = adcseq_pkg::ADDR_CTL_FIRST;
               rd_next    = 1'b1;
               state_next = adcseq_pkg::ST_POLL;
            end else if (irq_sync) begin
               addr_next  = adcseq_pkg::ADDR_RES_LOW;
               rd_next    = 1'b1;
               state_next = adcseq_pkg::ST_RD_LO;
            end
         end
         adcseq_pkg::ST_POLL: begin
            if (sample) begin
               if (rdata_sync[adcseq_pkg::BUSY_BIT]) begin
                  state_next = adcseq_pkg::ST_WAIT;
               end else begin
                  addr_next  = adcseq_pkg::ADDR_RES_LOW;
                  rd_next    = 1'b1;
                  state_next = adcseq_pkg::ST_RD_LO;
               end
            end
         end
         adcseq_pkg::ST_RD_LO: begin
            if (sample) begin
               low_next   = rdata_sync;
               addr_next  = adcseq_pkg::ADDR_RES_HIGH;
               rd_next    = 1'b1;
               state_next = adcseq_pkg::ST_RD_HI;
            end
         end
         adcseq_pkg::ST_RD_HI: begin
            if (sample) begin
               result_next = fmt_reg ? {rdata_sync[3:0], low_reg}
                                     : {rdata_sync, low_reg[7:4]};
               done_next   = 1'b1;
               busy_next   = 1'b0;
               addr_next   = adcseq_pkg::ADDR_NONE;
               state_next  = adcseq_pkg::ST_IDLE;
            end
         end
         default: begin
            busy_next  = 1'b0;
            state_next = adcseq_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg  <= adcseq_pkg::ST_IDLE;
         addr_reg   <= adcseq_pkg::ADDR_NONE;
         wdata_reg  <= adcseq_pkg::BYTE_ZERO;
         wr_reg     <= 1'b0;
         rd_reg     <= 1'b0;
         wait_reg   <= '0;
         low_reg    <= adcseq_pkg::BYTE_ZERO;
         result_reg <= adcseq_pkg::RESULT_ZERO;
         done_reg   <= 1'b0;
         busy_reg   <= 1'b0;
         {div_reg, src_reg, chan_reg, pin_reg} <= '0;
         {ref_reg, fmt_reg, irq_reg} <= '0;
      end else begin
         state_reg  <= state_next;
         addr_reg   <= addr_next;
         wdata_reg  <= wdata_next;
         wr_reg     <= wr_next;
         rd_reg     <= rd_next;
         wait_reg   <= wait_next;
         low_reg    <= low_next;
         result_reg <= result_next;
         done_reg   <= done_next;
         busy_reg   <= busy_next;
         {div_reg, src_reg, chan_reg} <= {div_next, src_next, chan_next};
         {pin_reg, ref_reg} <= {pin_next, ref_next};
         {fmt_reg, irq_reg} <= {fmt_next, irq_next};
      end
   end

   assign busy_o      = busy_reg;
   assign done_o      = done_reg;
   assign result_o    = result_reg;
   assign dev_addr_o  = addr_reg;
   assign dev_wdata_o = wdata_reg;
   assign dev_wr_o    = wr_reg;
   assign dev_rd_o    = rd_reg;
endmodule // adcseq_host
`default_nettype wire

//--- src/adcseq_pkg.sv
`default_nettype none
package adcseq_pkg;
   // device register addresses, as seen on the host's register port
   localparam logic [3:0] ADDR_CTL_FIRST  = 4'h0;
   localparam logic [3:0] ADDR_CTL_SECOND = 4'h1;
   localparam logic [3:0] ADDR_RES_LOW    = 4'h2;
   localparam logic [3:0] ADDR_RES_HIGH   = 4'h3;
   localparam logic [3:0] ADDR_INT_CTL    = 4'h4;
   localparam logic [3:0] ADDR_PIN_SEL_B  = 4'h5;
   localparam logic [3:0] ADDR_NONE       = 4'h0;

   // first control register layout
   localparam int START_BIT  = 7;
   localparam int BUSY_BIT   = 6;
   localparam int ENABLE_BIT = 5;
   localparam int FORMAT_BIT = 4;
   localparam int CHAN_LSB   = 0;
   // second control register layout
   localparam int SRC_LSB    = 5;
   localparam int REF_LSB    = 3;
   localparam int DIV_LSB    = 0;
   // interrupt control register layout
   localparam int GIE_BIT    = 0;
   localparam int AIE_BIT    = 1;
   localparam int AREQ_BIT   = 2;

   localparam logic [7:0] BYTE_ZERO   = 8'h00;
   localparam logic [7:0] BYTE_ONE    = 8'h01;
   localparam logic [3:0] CHAN_NONE   = 4'hF;
   localparam logic [2:0] SRC_EXT     = 3'h0;
   localparam logic [1:0] SRC_EXT_HI  = 2'h3;
   localparam logic [11:0] RESULT_ZERO = 12'h000;

   // cycles from read strobe to sampling the synchronised data
   localparam logic [1:0] READ_WAIT   = 2'h3;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0000,
      ST_DIV       = 4'b0001,
      ST_PWR       = 4'b0010,
      ST_PIN       = 4'b0011,
      ST_SRC       = 4'b0100,
      ST_IRQ_CLR   = 4'b0101,
      ST_IRQ_EN    = 4'b0110,
      ST_START_LO  = 4'b0111,
      ST_START_HI  = 4'b1000,
      ST_START_END = 4'b1001,
      ST_WAIT      = 4'b1010,
      ST_POLL      = 4'b1011,
      ST_RD_LO     = 4'b1100,
      ST_RD_HI     = 4'b1101,
      ST_OFF       = 4'b1110
   } adcseq_state_t;
endpackage
`default_nettype wire

//--- src/adcseq_sync.sv
`default_nettype none
module adcseq_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] q_reg;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_reg <= '0;
         q_reg    <= '0;
      end else begin
         meta_reg <= d_i;
         q_reg    <= meta_reg;
      end
   end

   assign q_o = q_reg;
endmodule // adcseq_sync
`default_nettype wire

//--- dv/adcseq_host_monitor.sv
`default_nettype none
module adcseq_host_monitor (
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic        cmd_start_i,
   input wire logic        cmd_power_down_i,
   input wire logic [2:0]  cfg_divider_i,
   input wire logic        busy_o,
   input wire logic        done_o,
   input wire logic [11:0] result_o,
   input wire logic [3:0]  dev_addr_o,
   input wire logic [7:0]  dev_wdata_o,
   input wire logic        dev_wr_o,
   input wire logic        dev_rd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       go_w, down_w, wr0_w, wr1_w, wr4_w, int_w;
   logic [3:0] chan_reg;
   assign go_w   = !busy_o && cmd_start_i;
   assign down_w = !busy_o && !cmd_start_i && cmd_power_down_i;
   assign wr0_w  = dev_wr_o && dev_addr_o == adcseq_pkg::ADDR_CTL_FIRST;
   assign wr1_w  = dev_wr_o && dev_addr_o == adcseq_pkg::ADDR_CTL_SECOND;
   assign wr4_w  = dev_wr_o && dev_addr_o == adcseq_pkg::ADDR_INT_CTL;
   assign int_w  = dev_wdata_o[7:5] != 3'h0 && dev_wdata_o[7:6] != 2'h3;
   // last channel code written to the first control register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         chan_reg <= 4'h0;
      end else if (wr0_w) begin
         chan_reg <= dev_wdata_o[3:0];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   a_cmd_busy: assert property (
      go_w || down_w |=> busy_o) else $error("busy not raised");
   a_div_first: assert property (
      go_w |=> ##1 wr1_w && dev_wdata_o[7:5] == 3'h0
         && dev_wdata_o[2:0] == $past(cfg_divider_i, 2))
      else $error("divider not written first");
   a_power_on: assert property (
      go_w |=> ##2 wr0_w && dev_wdata_o[5]) else $error("no power up");
   a_start_pulse: assert property (
      wr0_w && dev_wdata_o[7] |-> $past(wr0_w) && !$past(dev_wdata_o[7])
         ##1 wr0_w && !dev_wdata_o[7]) else $error("start not low high low");
   a_park_chan: assert property (
      wr1_w && int_w |-> chan_reg >= 4'h6) else $error("channel not parked");
   a_irq_clear: assert property (
      wr4_w && dev_wdata_o[1] |-> $past(wr4_w) && !$past(dev_wdata_o[2]))
      else $error("request not cleared first");
   a_rd_hold: assert property (
      $rose(dev_rd_o) |=> (dev_rd_o && $stable(dev_addr_o))[*3])
      else $error("read strobe too short");
   a_done_pulse: assert property (
      done_o |-> !busy_o ##1 !done_o) else $error("done not a pulse");
   a_result_hold: assert property (
      !done_o |-> $stable(result_o)) else $error("result moved");
   a_power_down: assert property (
      down_w |=> ##1 wr0_w && !dev_wdata_o[5] && !busy_o)
      else $error("power down not written");
   c_done: cover property (done_o);
   c_down: cover property (down_w);
   c_internal: cover property (wr1_w && int_w);
endmodule // adcseq_host_monitor
bind adcseq_host adcseq_host_monitor u_mon (.clk_i(clk_i), .resetn_i(resetn_i),
   .cmd_start_i(cmd_start_i), .cmd_power_down_i(cmd_power_down_i),
   .cfg_divider_i(cfg_divider_i), .busy_o(busy_o), .done_o(done_o),
   .result_o(result_o), .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o),
   .dev_wr_o(dev_wr_o), .dev_rd_o(dev_rd_o));
`default_nettype wire

//--- dv/adcseq_dev_model.sv
`default_nettype none
module adcseq_dev_model (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [11:0] sample_i,
   output logic      [7:0]  rdata_o,
   output logic             irq_o,
   output logic             fault_o,
   output logic      [7:0]  second_o,
   output logic             power_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  ctl0_reg, ctl1_reg, pin_reg, lo_reg, hi_reg, last_reg, mux;
   logic [2:0]  int_reg;
   logic        armed_reg;
   logic [11:0] cnt_reg, smp_reg;
   always_comb begin
      case (addr_i)
         4'h0: mux = ctl0_reg;
         4'h1: mux = ctl1_reg;
         4'h2: mux = lo_reg;
         4'h3: mux = hi_reg;
         4'h4: mux = {5'h00, int_reg};
         4'h5: mux = pin_reg;
         default: mux = 8'h00;
      endcase
   end
   // released bus shows the inverse of the last value
   assign rdata_o = rd_i ? mux : ~last_reg;
   assign irq_o = int_reg[2] & int_reg[1] & int_reg[0];
   assign second_o = ctl1_reg;
   assign power_o = ctl0_reg[5];
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {ctl0_reg, ctl1_reg, pin_reg, lo_reg, hi_reg, last_reg} <= '0;
         {int_reg, armed_reg, cnt_reg, smp_reg, fault_o} <= '0;
      end else begin
         if (rd_i) last_reg <= mux;
         if (cnt_reg != 12'h000) cnt_reg <= cnt_reg - 12'h001;
         if (cnt_reg == 12'h001) begin
            ctl0_reg[6] <= 1'b0;
            int_reg[2] <= 1'b1;
            hi_reg <= ctl0_reg[4] ? {4'h0, smp_reg[11:8]} : smp_reg[11:4];
            lo_reg <= ctl0_reg[4] ? smp_reg[7:0] : {smp_reg[3:0], 4'h0};
         end
         if (wr_i && addr_i == 4'h0) begin
            ctl0_reg <= {wdata_i[7], ctl0_reg[6], wdata_i[5:0]};
            armed_reg <= wdata_i[7];
            if (!wdata_i[5]) begin
               ctl0_reg[6] <= 1'b0;
               cnt_reg <= 12'h000;
            end
            if (armed_reg && !wdata_i[7]) begin
               if (!wdata_i[5]) fault_o <= 1'b1;
               else begin
                  ctl0_reg[6] <= 1'b1;
                  cnt_reg <= 12'h010 << ctl1_reg[2:0];
                  smp_reg <= sample_i;
               end
            end
         end
         // every source and reference code kept
         if (wr_i && addr_i == 4'h1) begin
            ctl1_reg <= wdata_i;
            if (wdata_i[7:5] != 3'h0 && wdata_i[7:6] != 2'h3
                && ctl0_reg[3:0] < 4'h6) fault_o <= 1'b1;
         end
         if (wr_i && addr_i == 4'h4) begin
            int_reg <= {int_reg[2] & wdata_i[2], wdata_i[1:0]};
            if (wdata_i[1] && int_reg[2]) fault_o <= 1'b1;
         end
         if (wr_i && addr_i == 4'h5) pin_reg <= wdata_i;
      end
   end
endmodule // adcseq_dev_model
`default_nettype wire

//--- dv/adcseq_bench.sv
`default_nettype none
module adcseq_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [2:0] dv; logic [2:0] src; logic [3:0] ch; logic [1:0] rs;
      logic fmt; logic irq; logic [11:0] smp;
   } adcseq_row_t;
   adcseq_row_t rows [8] = '{
      '{3'h0, 3'h0, 4'h0, 2'h0, 1'h0, 1'h0, 12'hFFF},
      '{3'h1, 3'h1, 4'h6, 2'h1, 1'h1, 1'h0, 12'h000},
      '{3'h2, 3'h2, 4'h7, 2'h2, 1'h0, 1'h1, 12'hA5C},
      '{3'h3, 3'h3, 4'h0, 2'h3, 1'h1, 1'h1, 12'h001},
      '{3'h4, 3'h4, 4'h3, 2'h0, 1'h0, 1'h0, 12'h800},
      '{3'h5, 3'h5, 4'h0, 2'h1, 1'h1, 1'h1, 12'h7FF},
      '{3'h6, 3'h6, 4'h5, 2'h2, 1'h0, 1'h0, 12'h123},
      '{3'h7, 3'h7, 4'h2, 2'h3, 1'h1, 1'h1, 12'hFFF}};
   logic clk_i = 1'b0, resetn_i = 1'b0, cmd_start_i = 1'b0;
   logic cmd_power_down_i = 1'b0, cfg_format_i = 1'b0, cfg_use_irq_i = 1'b0;
   logic [2:0] cfg_divider_i = 3'h0, cfg_source_i = 3'h0;
   logic [3:0] cfg_channel_i = 4'h0, dev_addr;
   logic [1:0] cfg_reference_i = 2'h0;
   logic [7:0] cfg_pin_mask_i = 8'h01, dev_wdata, dev_rdata, second;
   logic [11:0] smp = 12'h000, result_o;
   logic busy_o, done_o, dev_wr, dev_rd, dev_irq, fault, power;
   int fail_count = 0, tests_run = 0;
   always #10 clk_i = ~clk_i;
   adcseq_host dut (.clk_i(clk_i), .resetn_i(resetn_i),
      .cmd_start_i(cmd_start_i), .cmd_power_down_i(cmd_power_down_i),
      .cfg_divider_i(cfg_divider_i), .cfg_source_i(cfg_source_i),
      .cfg_channel_i(cfg_channel_i), .cfg_pin_mask_i(cfg_pin_mask_i),
      .cfg_reference_i(cfg_reference_i), .cfg_format_i(cfg_format_i),
      .cfg_use_irq_i(cfg_use_irq_i), .busy_o(busy_o), .done_o(done_o),
      .result_o(result_o), .dev_addr_o(dev_addr), .dev_wdata_o(dev_wdata),
      .dev_wr_o(dev_wr), .dev_rd_o(dev_rd), .dev_rdata_i(dev_rdata),
      .dev_irq_i(dev_irq));
   adcseq_dev_model u_dev (.clk_i(clk_i), .resetn_i(resetn_i),
      .addr_i(dev_addr), .wdata_i(dev_wdata), .wr_i(dev_wr), .rd_i(dev_rd),
      .sample_i(smp), .rdata_o(dev_rdata), .irq_o(dev_irq),
      .fault_o(fault), .second_o(second), .power_o(power));
   task automatic check_word(input string what, input logic [11:0] e,
                             input logic [11:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic check_flag(input string what, input logic e, input logic g);
      check_word(what, {11'h000, e}, {11'h000, g});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic go(input adcseq_row_t r);
      @(posedge clk_i);
      {cfg_divider_i, cfg_source_i, cfg_channel_i} <= {r.dv, r.src, r.ch};
      {cfg_reference_i, cfg_format_i, cfg_use_irq_i} <= {r.rs, r.fmt, r.irq};
      smp <= r.smp;
      cfg_pin_mask_i <= {r.ch, r.ch};
      cmd_start_i <= 1'b1;
      @(posedge clk_i);
      cmd_start_i <= 1'b0;
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (done_o !== 1'b1 && n < 5000);
      check_flag("done", 1'b1, done_o);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      check_flag("busy in reset", 1'b0, busy_o);
      resetn_i <= 1'b1;
      foreach (rows[i]) begin
         go(rows[i]);
         wait_done();
         check_word("result", rows[i].smp, result_o);
         check_word("setup", {4'h0, rows[i].src, rows[i].rs, rows[i].dv},
                    {4'h0, second});
         check_flag("order fault", 1'b0, fault);
         if (rows[i].src == 3'h0 || rows[i].src[2:1] == 2'h3)
            check_word("pin select", {4'h0, rows[i].ch, rows[i].ch},
                       {4'h0, u_dev.pin_reg});
         $display("row %0d finished", i);
      end
      // second start while busy is ignored
      go(rows[2]);
      repeat (30) @(posedge clk_i);
      go(rows[0]);
      wait_done();
      check_word("refused start", rows[2].smp, result_o);
      repeat (3) @(negedge clk_i);
      check_flag("no rerun", 1'b0, busy_o);
      $display("busy refusal finished");
      @(posedge clk_i);
      cmd_power_down_i <= 1'b1;
      @(posedge clk_i);
      cmd_power_down_i <= 1'b0;
      repeat (3) @(negedge clk_i);
      check_flag("power", 1'b0, power);
      $display("power down finished");
      go(rows[3]);
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'b0;
      @(negedge clk_i);
      check_flag("busy reset", 1'b0, busy_o);
      check_word("result reset", 12'h000, result_o);
      @(posedge clk_i);
      resetn_i <= 1'b1;
      go(rows[1]);
      wait_done();
      check_word("after reset", rows[1].smp, result_o);
      $display("mid run reset finished");
      tally_and_finish();
   end
endmodule // adcseq_bench
`default_nettype wire
